// *** common/sfc_pkg.sv ***
// Purpose : Constants for the synthesizer function control logic
// Assumes : 24-bit serial words, word type in the two low bits
`default_nettype none
package sfc_pkg;
    // -------------------------------------------------------------------
    // Word format
    // -------------------------------------------------------------------
    localparam int         WORD_W          = 24;
    localparam logic [1:0] TYPE_REF        = 2'h0;
    localparam logic [1:0] TYPE_AB         = 2'h1;
    localparam logic [1:0] TYPE_FUNC       = 2'h2;
    localparam logic [1:0] TYPE_INIT       = 2'h3;
    // -------------------------------------------------------------------
    // Function word fields
    // -------------------------------------------------------------------
    localparam int         FB_HOLD         = 2;
    localparam int         FB_PD_ARM       = 3;
    localparam int         FB_MON_LSB      = 4;
    localparam int         FB_CP_OFF       = 8;
    localparam int         FB_FL_EN        = 9;
    localparam int         FB_FL_MODE      = 10;
    localparam int         FB_TMO_LSB      = 11;
    localparam int         FB_BASE_LSB     = 15;
    localparam int         FB_BOOST_LSB    = 18;
    localparam int         FB_PD_SYNC      = 21;
    localparam int         FB_PRE_LSB      = 22;
    // -------------------------------------------------------------------
    // AB word fields
    // -------------------------------------------------------------------
    localparam int         AB_BOOST        = 21;
    // -------------------------------------------------------------------
    // Reset values and timing
    // -------------------------------------------------------------------
    localparam logic [23:0] FUNC_RESET     = 24'h000000;
    localparam int          TMO_STEP       = 4;
    localparam int          SYNC_STAGES    = 2;
    typedef enum logic [1:0] {SFC_RUN, SFC_PEND, SFC_DOWN} sfc_pwr_e;
endpackage
`default_nettype wire

// *** logic/sfc_serial_rx.sv ***
// Purpose : Three-wire serial word receiver
// Assumes : Link pins asynchronous, sampled by sys_clk
// Notes   : Shifts on clock rise, latches on enable rise
`timescale 1ns/10ps
`default_nettype none
module sfc_serial_rx #(
    parameter int WORD_W = sfc_pkg::WORD_W
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    // Link pins
    input  wire logic              ser_clk,
    input  wire logic              ser_data,
    input  wire logic              ser_le,
    // Latched word
    output logic                   word_valid,
    output logic [WORD_W-1:0]      word_data
);
    initial
    begin
        if (WORD_W < 3) $error("word too short");
    end

    // -------------------------------------------------------------------
    // Pin synchronisers, then one more stage for edge detection
    // -------------------------------------------------------------------
    logic [2:0]        meta_q;
    logic [2:0]        sync_q;
    logic [2:0]        last_q;
    logic [WORD_W-1:0] shift_q;
    logic [WORD_W-1:0] next_shift;
    logic [WORD_W-1:0] next_word;
    logic              next_valid;

    // Data is taken from the same synchronised sample as the clock edge,
    // so skew between the pins stays within one system cycle
    always_comb
    begin
        next_shift = shift_q;
        next_word  = word_data;
        next_valid = 1'b0;
        if (sync_q[0] && !last_q[0])
        begin
            next_shift = {shift_q[WORD_W-2:0], sync_q[1]};
        end
        if (sync_q[2] && !last_q[2])
        begin
            next_word  = shift_q;
            next_valid = 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        meta_q <= {ser_le, ser_data, ser_clk};
        sync_q <= meta_q;
        last_q <= sync_q;
        if (sys_rst)
        begin
            shift_q    <= '0;
            word_data  <= '0;
            word_valid <= 1'b0;
        end
        else
        begin
            shift_q    <= next_shift;
            word_data  <= next_word;
            word_valid <= next_valid;
        end
    end
endmodule // sfc_serial_rx
`default_nettype wire

// *** logic/sfc_function_ctrl.sv ***
// Purpose : Function word control of a PLL synthesizer
// Assumes : Pins and analog strobes asynchronous to sys_clk
// Notes   : Power-down state never blocks the serial input
`timescale 1ns/10ps
`default_nettype none
module sfc_function_ctrl #(
    parameter int TMO_STEP = sfc_pkg::TMO_STEP
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    // Serial link pins
    input  wire logic       ser_clk,
    input  wire logic       ser_data,
    input  wire logic       ser_le,
    // Chip enable pin and charge pump event strobe
    input  wire logic       chip_enable,
    input  wire logic       cp_event,
    // Internal sources for the monitor pin
    input  wire logic [7:0] monitor_src,
    // Counter and charge pump control
    output logic            counters_load,
    output logic            timeout_load,
    output logic            cp_tristate,
    output logic [2:0]      cp_current_code,
    output logic            clkdet_reset,
    output logic            powered_down,
    output logic [1:0]      prescaler_select,
    // Monitor pin and status
    output logic            monitor_output_pin,
    output logic            current_boost_bit,
    output logic            fastlock_active
);
    initial
    begin
        if (TMO_STEP < 1 || TMO_STEP > 15) $error("TMO_STEP out of range");
    end

    // -------------------------------------------------------------------
    // Serial receiver
    // -------------------------------------------------------------------
    logic                           word_valid;
    logic [sfc_pkg::WORD_W-1:0]     word_data;

    sfc_serial_rx #(
        .WORD_W     (sfc_pkg::WORD_W)
    ) u_rx (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .ser_clk    (ser_clk),
        .ser_data   (ser_data),
        .ser_le     (ser_le),
        .word_valid (word_valid),
        .word_data  (word_data)
    );

    // -------------------------------------------------------------------
    // Synchronisers for chip enable, pump event and monitor sources
    // -------------------------------------------------------------------
    logic [9:0] meta_q;
    logic [9:0] sync_q;
    logic       evt_last_q;
    logic       ce_s;
    logic       evt_s;
    logic       evt_pulse;

    assign ce_s      = sync_q[0];
    assign evt_s     = sync_q[1];
    assign evt_pulse = evt_s && !evt_last_q;

    // Pins pass two flops before any logic reads them
    always_ff @(posedge sys_clk)
    begin
        meta_q <= {monitor_src, cp_event, chip_enable};
        sync_q <= meta_q;
    end

    // -------------------------------------------------------------------
    // Word decode
    // -------------------------------------------------------------------
    function automatic logic is_type(input logic [23:0] w, input logic [1:0] t);
        is_type = (w[1:0] == t);
    endfunction

    // Three-bit fields recur in the word; one helper keeps the width in one place
    function automatic logic [2:0] field3(input logic [23:0] w, input int lsb);
        field3 = w[lsb +: 3];
    endfunction

    logic func_wr;
    logic init_wr;
    logic ab_wr;

    assign init_wr = word_valid && is_type(word_data, sfc_pkg::TYPE_INIT);
    assign func_wr = word_valid && (is_type(word_data, sfc_pkg::TYPE_FUNC)
                                    || init_wr);
    assign ab_wr   = word_valid && is_type(word_data, sfc_pkg::TYPE_AB);

    // -------------------------------------------------------------------
    // Function word and fastlock state
    // -------------------------------------------------------------------
    typedef sfc_pkg::sfc_pwr_e sfc_pwr_state_t;

    logic [23:0]         func_q;
    logic [23:0]         next_func;
    logic                boost_q;
    logic                next_boost;
    logic [7:0]          tmo_q;
    logic [7:0]          next_tmo;
    logic                next_pulse;
    sfc_pwr_state_t      pwr_q;
    sfc_pwr_state_t      next_pwr;

    logic       hold;
    logic       pd_arm;
    logic       pd_sync;
    logic       fl_en;
    logic       fl_mode2;
    logic [3:0] tmo_code;
    logic [7:0] tmo_len;
    logic       pd_any;

    assign hold     = func_q[sfc_pkg::FB_HOLD];
    assign pd_arm   = func_q[sfc_pkg::FB_PD_ARM];
    assign pd_sync  = func_q[sfc_pkg::FB_PD_SYNC];
    assign fl_en    = func_q[sfc_pkg::FB_FL_EN];
    assign fl_mode2 = func_q[sfc_pkg::FB_FL_MODE];
    assign tmo_code = func_q[sfc_pkg::FB_TMO_LSB +: 4];
    assign tmo_len  = 8'((32'(tmo_code) + 1) * TMO_STEP);
    assign pd_any   = (pwr_q == sfc_pkg::SFC_DOWN) || !ce_s;

    // Timeout counts pump events, so its length tracks the PFD rate
    always_comb
    begin
        next_func  = func_q;
        next_boost = boost_q;
        next_tmo   = tmo_q;
        next_pulse = init_wr;
        if (func_wr)
        begin
            next_func = word_data;
        end
        // Expiry clears the boost bit; a fresh write of 1 wins over it
        if (pd_any || !(fl_en && fl_mode2) || !boost_q)
        begin
            next_tmo = '0;
        end
        else if (evt_pulse)
        begin
            if (tmo_q + 8'h01 >= tmo_len)
            begin
                next_boost = 1'b0;
                next_tmo   = '0;
            end
            else
            begin
                next_tmo = tmo_q + 8'h01;
            end
        end
        if (ab_wr)
        begin
            next_boost = word_data[sfc_pkg::AB_BOOST];
            next_tmo   = '0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            evt_last_q <= 1'b0;
            func_q     <= sfc_pkg::FUNC_RESET;
            boost_q    <= 1'b0;
            tmo_q      <= '0;
        end
        else
        begin
            evt_last_q <= evt_s;
            func_q     <= next_func;
            boost_q    <= next_boost;
            tmo_q      <= next_tmo;
        end
    end

    // -------------------------------------------------------------------
    // Power-down sequencing
    // -------------------------------------------------------------------
    always_comb
    begin
        next_pwr = pwr_q;
        case (pwr_q)
            sfc_pkg::SFC_RUN:
            begin
                if (func_wr && ce_s && word_data[sfc_pkg::FB_PD_ARM])
                begin
                    if (word_data[sfc_pkg::FB_PD_SYNC])
                        next_pwr = sfc_pkg::SFC_PEND;
                    else
                        next_pwr = sfc_pkg::SFC_DOWN;
                end
            end
            sfc_pkg::SFC_PEND:
            begin
                if (!pd_arm || !ce_s)
                    next_pwr = sfc_pkg::SFC_RUN;
                else if (!pd_sync)
                    next_pwr = sfc_pkg::SFC_DOWN;
                else if (evt_pulse)
                    next_pwr = sfc_pkg::SFC_DOWN;
            end
            sfc_pkg::SFC_DOWN:
            begin
                // Programmed modes only act while chip enable is high
                if (!pd_arm || !ce_s)
                    next_pwr = sfc_pkg::SFC_RUN;
            end
            default:
                next_pwr = sfc_pkg::SFC_RUN;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            pwr_q <= sfc_pkg::SFC_RUN;
        end
        else
        begin
            pwr_q <= next_pwr;
        end
    end

    // -------------------------------------------------------------------
    // Output decode
    // -------------------------------------------------------------------
    logic       pd_next;
    logic       load_next;
    logic [2:0] code_next;
    logic       fl_next;
    logic [2:0] mon_sel;
    logic       next_timeout_load;
    logic       next_cp_tristate;
    logic       next_monitor;
    logic [1:0] next_prescaler;

    // Outputs other than the monitor pin (its select comes from func_q) are decoded from
    // next-state values, so every flag moves in the same cycle as the state that it reports
    always_comb
    begin
        pd_next           = (next_pwr == sfc_pkg::SFC_DOWN) || !ce_s;
        // Both counters share one load so releasing hold starts them together
        load_next         = next_func[sfc_pkg::FB_HOLD] || pd_next
                            || next_pulse;
        next_timeout_load = pd_next || (next_tmo == 8'h00);
        next_cp_tristate  = load_next || next_func[sfc_pkg::FB_CP_OFF];
        fl_next           = next_func[sfc_pkg::FB_FL_EN] && next_boost;
        if (fl_next)
        begin
            code_next = field3(next_func, sfc_pkg::FB_BOOST_LSB);
        end
        else
        begin
            code_next = field3(next_func, sfc_pkg::FB_BASE_LSB);
        end
        mon_sel           = field3(func_q, sfc_pkg::FB_MON_LSB);
        next_monitor      = sync_q[2 + 32'(mon_sel)];
        // Host keeps the divided output within range; not checked here
        next_prescaler    = next_func[sfc_pkg::FB_PRE_LSB +: 2];
    end

    // -------------------------------------------------------------------
    // Output registers
    // -------------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            counters_load      <= 1'b1;
            timeout_load       <= 1'b1;
            cp_tristate        <= 1'b1;
            cp_current_code    <= 3'h0;
            clkdet_reset       <= 1'b1;
            powered_down       <= 1'b1;
            prescaler_select   <= 2'h0;
            monitor_output_pin <= 1'b0;
            current_boost_bit  <= 1'b0;
            fastlock_active    <= 1'b0;
        end
        else
        begin
            counters_load      <= load_next;
            timeout_load       <= next_timeout_load;
            cp_tristate        <= next_cp_tristate;
            cp_current_code    <= code_next;
            clkdet_reset       <= pd_next;
            powered_down       <= pd_next;
            prescaler_select   <= next_prescaler;
            monitor_output_pin <= next_monitor;
            current_boost_bit  <= next_boost;
            fastlock_active    <= fl_next;
        end
    end
endmodule // sfc_function_ctrl
`default_nettype wire

// *** verification/sfc_function_ctrl_checker.sv ***
// Purpose : Port assertions for the function control block
// Assumes : Single sys_clk domain, synchronous reset
// Notes   : Quiet counter bounds the prescaler, power-down and boost reactions to their cause
`timescale 1ns/10ps
`default_nettype none
module sfc_function_ctrl_checker (
    // Clock, reset and causes
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       ser_le,
    input  wire logic       chip_enable,
    input  wire logic       cp_event,
    // Observed outputs
    input  wire logic       counters_load,
    input  wire logic       timeout_load,
    input  wire logic       cp_tristate,
    input  wire logic       clkdet_reset,
    input  wire logic       powered_down,
    input  wire logic [1:0] prescaler_select,
    input  wire logic       current_boost_bit,
    input  wire logic       fastlock_active
);
    logic [7:0] quiet;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Cycles since ser_le, cp_event or a low chip_enable was last seen
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || ser_le || cp_event || !chip_enable)
            quiet <= 8'h00;
        else if (quiet != 8'hFF)
            quiet <= quiet + 8'h01;
    end
    a_ce_low_down: assert property (!chip_enable [*6] |-> powered_down)
        else $error("enable low without power-down");
    a_down_loads_cnt: assert property (powered_down |-> counters_load && timeout_load)
        else $error("power-down without counter load");
    a_down_pump_off: assert property (powered_down |-> cp_tristate && clkdet_reset)
        else $error("power-down with pump or detect active");
    a_load_pump_off: assert property (counters_load |-> cp_tristate)
        else $error("counter load with pump active");
    a_fast_needs_boost: assert property (fastlock_active |-> current_boost_bit)
        else $error("fastlock without boost bit");
    a_presc_on_latch: assert property ($changed(prescaler_select) |-> quiet < 8)
        else $error("prescaler changed without latch");
    a_down_has_cause: assert property ($rose(powered_down) |-> quiet < 8)
        else $error("power-down without cause");
    a_boost_drop_cause: assert property ($fell(current_boost_bit) |-> quiet < 8)
        else $error("boost cleared without cause");
endmodule // sfc_function_ctrl_checker
bind sfc_function_ctrl sfc_function_ctrl_checker u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .ser_le(ser_le), .chip_enable(chip_enable), .cp_event(cp_event),
    .counters_load(counters_load), .timeout_load(timeout_load), .cp_tristate(cp_tristate),
    .clkdet_reset(clkdet_reset), .powered_down(powered_down),
    .prescaler_select(prescaler_select), .current_boost_bit(current_boost_bit),
    .fastlock_active(fastlock_active));
`default_nettype wire

// *** verification/sfc_host_model.sv ***
// Purpose : Host side of the three-wire link
// Assumes : 48 ns link clock, idle low between frames
// Notes   : Data line shows the inverse of the last bit when idle
`timescale 1ns/10ps
`default_nettype none
module sfc_host_model (
    // Link pins
    output logic ser_clk,
    output logic ser_data,
    output logic ser_le
);
    initial
    begin
        ser_clk  = 1'b0;
        ser_data = 1'b0;
        ser_le   = 1'b0;
    end
    // Word type sits in the two last bits of each frame
    task automatic send_word(input logic [23:0] w);
        for (int i = 23; i >= 0; i--)
        begin
            ser_data = w[i];
            #12 ser_clk = 1'b1;
            #24 ser_clk = 1'b0;
            #12;
        end
        #24 ser_le = 1'b1;
        #48 ser_le = 1'b0;
        ser_data = ~w[0];
    endtask
endmodule // sfc_host_model
`default_nettype wire

// *** verification/sfc_function_ctrl_bench.sv ***
// Purpose : Self-checking bench for the function control block
// Assumes : Shortened timeout step of 2 pump events
// Notes   : Waits after each word cover the sync and latch delay
`timescale 1ns/10ps
`default_nettype none
module sfc_function_ctrl_bench;
    localparam int STEP = 2;
    logic sys_clk, sys_rst, chip_enable, cp_event;
    logic [7:0] monitor_src;
    wire  ser_clk, ser_data, ser_le;
    logic counters_load, timeout_load, cp_tristate, clkdet_reset, powered_down;
    logic [2:0] cp_current_code;
    logic [1:0] prescaler_select;
    logic monitor_output_pin, current_boost_bit, fastlock_active;
    int n_fail, comparisons, cycles;
    logic [1:0] p;
    logic [2:0] ba, bo;
    logic [3:0] tc;
    sfc_host_model u_sfc_host_model (.ser_clk(ser_clk), .ser_data(ser_data), .ser_le(ser_le));
    sfc_function_ctrl #(.TMO_STEP(STEP)) u_sfc_function_ctrl (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .ser_clk(ser_clk), .ser_data(ser_data), .ser_le(ser_le),
        .chip_enable(chip_enable), .cp_event(cp_event), .monitor_src(monitor_src),
        .counters_load(counters_load), .timeout_load(timeout_load),
        .cp_tristate(cp_tristate), .cp_current_code(cp_current_code),
        .clkdet_reset(clkdet_reset), .powered_down(powered_down),
        .prescaler_select(prescaler_select), .monitor_output_pin(monitor_output_pin),
        .current_boost_bit(current_boost_bit), .fastlock_active(fastlock_active));
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic results();
        if (n_fail == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
            n_fail++;
        end
    endtask
    // Function word from its fields; bit 8 keeps the pump enabled
    function automatic logic [23:0] fw(input logic s, input logic [3:0] t, input logic md,
        input logic en, input logic [2:0] mn, input logic arm, input logic hold);
        return {p, s, bo, ba, t, md, en, 2'h0, mn, arm, hold, sfc_pkg::TYPE_FUNC};
    endfunction
    task automatic wr(input logic [23:0] w);
        u_sfc_host_model.send_word(w);
        repeat (8) @(posedge sys_clk);
        #1;
    endtask
    task automatic ab(input logic b);
        wr({2'h0, b, 19'h00000, sfc_pkg::TYPE_AB});
    endtask
    task automatic pulse(input int n);
        repeat (n)
        begin
            @(posedge sys_clk) cp_event <= 1'b1;
            repeat (4) @(posedge sys_clk);
            cp_event <= 1'b0;
            repeat (4) @(posedge sys_clk);
        end
        #1;
    endtask
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles > 60000)
        begin
            n_fail++;
            results();
        end
    end
    initial
    begin
        {n_fail, comparisons, cycles} = '0;
        {sys_rst, chip_enable, cp_event, monitor_src} = {1'b1, 1'b1, 1'b0, 8'h00};
        void'($urandom(32'h4e64));
        p  = 2'($urandom());  // Host is trusted to keep the prescaler output in range
        ba = 3'($urandom());
        bo = ~ba;
        tc = 4'($urandom_range(2));
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        for (int m = 0; m < 8; m++)
        begin
            monitor_src <= 8'($urandom());
            wr(fw(1'b0, tc, 1'b0, 1'b0, 3'(m), 1'b0, 1'b0));
            check("monitor", 8'(monitor_output_pin), 8'(monitor_src[m]));
        end
        check("presc", 8'(prescaler_select), 8'(p));
        wr({~p, 20'h00000, sfc_pkg::TYPE_REF});
        check("presc_ref", 8'(prescaler_select), 8'(p));
        wr(fw(1'b0, tc, 1'b0, 1'b0, 3'h0, 1'b0, 1'b1));
        check("hold", 8'({counters_load, cp_tristate, powered_down}), 8'h06);
        wr(fw(1'b0, tc, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0));
        check("unhold", 8'({counters_load, cp_tristate}), 8'h00);
        @(posedge sys_clk) chip_enable <= 1'b0;
        p = ~p;
        wr(fw(1'b0, tc, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0));
        check("ce_down", 8'({powered_down, counters_load, timeout_load, cp_tristate,
            clkdet_reset}), 8'h1F);
        check("presc_down", 8'(prescaler_select), 8'(p));
        @(posedge sys_clk) chip_enable <= 1'b1;
        repeat (8) @(posedge sys_clk);
        #1;
        check("ce_up", 8'(powered_down), 8'h00);
        wr(fw(1'b0, tc, 1'b0, 1'b0, 3'h0, 1'b1, 1'b0));
        check("async_pd", 8'({powered_down, counters_load, cp_tristate}), 8'h07);
        wr(fw(1'b1, tc, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0));
        check("pd_off", 8'(powered_down), 8'h00);
        wr(fw(1'b1, tc, 1'b0, 1'b0, 3'h0, 1'b1, 1'b0));
        check("sync_wait", 8'(powered_down), 8'h00);
        pulse(1);
        check("sync_pd", 8'({powered_down, clkdet_reset}), 8'h03);
        wr(fw(1'b0, tc, 1'b1, 1'b0, 3'h0, 1'b0, 1'b0));
        ab(1'b1);
        check("fl_off", 8'({current_boost_bit, fastlock_active, cp_current_code}),
            8'({2'b10, ba}));
        wr(fw(1'b0, tc, 1'b0, 1'b1, 3'h0, 1'b0, 1'b0));
        ab(1'b1);
        check("fl1_on", 8'({fastlock_active, cp_current_code}), 8'({1'b1, bo}));
        pulse(8);
        check("fl1_hold", 8'(current_boost_bit), 8'h01);
        check("fl1_tmo", 8'(timeout_load), 8'h01);
        ab(1'b0);
        check("fl1_exit", 8'({current_boost_bit, cp_current_code}), 8'(ba));
        wr(fw(1'b0, tc, 1'b1, 1'b1, 3'h0, 1'b0, 1'b0));
        ab(1'b1);
        check("fl2_on", 8'(cp_current_code), 8'(bo));
        pulse((int'(tc) + 1) * STEP - 1);
        check("fl2_early", 8'(current_boost_bit), 8'h01);
        check("tmo_run", 8'(timeout_load), 8'h00);
        pulse(1);
        check("fl2_exp", 8'({current_boost_bit, fastlock_active, cp_current_code}),
            8'(ba));
        check("tmo_done", 8'(timeout_load), 8'h01);
        wr({~p, 20'h00000, sfc_pkg::TYPE_INIT});
        check("init", 8'({prescaler_select, counters_load}), 8'({~p, 1'b0}));
        results();
    end
endmodule // sfc_function_ctrl_bench
`default_nettype wire
